/* File: rtl/irr_recognizer.sv */
// Interrupt request recognition: sampling, masking, priority and acknowledge
`default_nettype none
module irr_recognizer #(
  parameter int unsigned NUM_LEVELS = irr_pkg::NUM_LEVELS,
  parameter int unsigned SAMPLES = irr_pkg::MIN_ASSERT_SAMPLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Falling-edge sample enable from the clock divider (one-cycle pulse)
  input wire logic sample_en,
  // External active-low request pins, bit 0 is the lowest request line
  input wire logic [NUM_LEVELS-1:0] ext_request_n,
  // Internal active-low requests from on-chip modules
  input wire logic [NUM_LEVELS-1:0] int_request_n,
  // Processor core: boundary reached, pending may be taken
  input wire logic take_boundary,
  // Processor core: acknowledge cycle terminated
  input wire logic ack_done,
  // Processor core: software write of the priority mask field
  input wire logic mask_write,
  input wire logic [2:0] mask_wdata,
  // Processor core: current priority mask field
  output logic [2:0] priority_mask_field,
  // Highest valid unmasked level, zero means none
  output logic [2:0] pending_level,
  // Non-maskable interrupt pending
  output logic nmi_pending,
  // Acknowledge cycle outputs
  output logic ack_active,
  output logic [2:0] function_code_lines,
  output logic [2:0] ack_addr_level,
  output logic [7:0] autovector,
  // Source of an external request, seen as integration block
  output logic from_system_integration_block
);
  // Registered state of the block
  typedef struct packed {
    irr_pkg::irr_state_t fsm;
    logic [2:0] mask;
    logic [2:0] ack_level;
    logic [2:0] fc;
    logic [7:0] vec;
    logic nmi_armed;
    logic nmi_event;
    logic ext_src;
    logic [2:0] pend;
  } irr_state_s_t;

  irr_state_s_t state;
  irr_state_s_t next_state;

  // Filtered valid per level
  logic [NUM_LEVELS-1:0] level_valid;
  // Filtered valid from external pins only, for source tagging
  logic [NUM_LEVELS-1:0] ext_valid;
  // Combined active-low request per level
  logic [NUM_LEVELS-1:0] combined_n;
  // Highest valid maskable level above mask
  logic [2:0] best_level;

  // pins are inputs only here, never driven
  assign combined_n = ext_request_n & int_request_n;

  // Two filters per level, one for the combined view and one for the external-only view
  genvar g;
  generate
    for (g = 0; g < NUM_LEVELS; g++)
    begin : g_line
      irr_line_filter #(.SAMPLES(SAMPLES)) u_comb (
        .clk_sys(clk_sys),
        .reset(reset),
        .sample_en(sample_en),
        .request_n(combined_n[g]),
        .valid(level_valid[g])
      );
      irr_line_filter #(.SAMPLES(SAMPLES)) u_ext (
        .clk_sys(clk_sys),
        .reset(reset),
        .sample_en(sample_en),
        .request_n(ext_request_n[g]),
        .valid(ext_valid[g])
      );
    end
  endgenerate

  // Priority encoder over maskable levels one to six
  always_comb
  begin
    best_level = 3'h0;
    // scan upward so the highest level wins
    for (int i = 0; i < NUM_LEVELS - 1; i++)
    begin
      // only levels above the mask pass
      if (level_valid[i] && (3'(i + 1) > state.mask))
      begin
        best_level = 3'(i + 1);
      end
    end
  end

  // Next-state logic
  always_comb
  begin
    next_state = state;
    // re-arm after line seven sampled negated
    if (!level_valid[NUM_LEVELS-1])
    begin
      next_state.nmi_armed = 1'b1;
    end
    // Software mask write
    if (mask_write)
    begin
      next_state.mask = mask_wdata;
    end
    next_state.pend = state.nmi_event ? irr_pkg::NMI_LEVEL : best_level;
    case (state.fsm)
      irr_pkg::IRR_IDLE:
      begin
        if (take_boundary && (state.pend != 3'h0))
        begin
          next_state.fsm = irr_pkg::IRR_ACK;
          next_state.ack_level = state.pend;
          next_state.fc = irr_pkg::FC_CPU_SPACE;
          next_state.vec = irr_pkg::AUTOVEC_BASE + {5'h00, state.pend};
          // external source appears as integration block
          next_state.ext_src = (state.pend == irr_pkg::NMI_LEVEL) ?
            ext_valid[NUM_LEVELS-1] : ext_valid[state.pend - 3'h1];
          next_state.mask = state.pend;
          // Consume the NMI event; a set further down still wins
          if (state.pend == irr_pkg::NMI_LEVEL)
          begin
            next_state.nmi_event = 1'b0;
          end
        end
      end
      irr_pkg::IRR_ACK:
      begin
        // Hold acknowledge until the cycle terminates
        if (ack_done)
        begin
          next_state.fsm = irr_pkg::IRR_DONE;
          next_state.fc = irr_pkg::FC_IDLE;
        end
      end
      irr_pkg::IRR_DONE:
      begin
        // One idle cycle before a new acknowledge
        next_state.fsm = irr_pkg::IRR_IDLE;
      end
      default:
      begin
        next_state.fsm = irr_pkg::IRR_IDLE;
      end
    endcase
    // Event sets come last so a set beats a same-cycle clear
    // edge then sustained low makes a valid NMI
    if (state.nmi_armed && level_valid[NUM_LEVELS-1])
    begin
      next_state.nmi_event = 1'b1;
      next_state.nmi_armed = 1'b0;
    end
    // mask drop from seven while line seven held
    if (mask_write && (state.mask == irr_pkg::NMI_LEVEL) &&
        (mask_wdata != irr_pkg::NMI_LEVEL) && level_valid[NUM_LEVELS-1])
    begin
      next_state.nmi_event = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state.fsm <= irr_pkg::IRR_IDLE;
      state.mask <= irr_pkg::MASK_RESET;
      state.ack_level <= 3'h0;
      state.fc <= irr_pkg::FC_IDLE;
      state.vec <= 8'h00;
      state.nmi_armed <= 1'b1;
      state.nmi_event <= 1'b0;
      state.ext_src <= 1'b0;
      state.pend <= 3'h0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Registered outputs
  assign priority_mask_field = state.mask;
  assign pending_level = state.pend;
  assign nmi_pending = state.nmi_event;
  assign ack_active = (state.fsm == irr_pkg::IRR_ACK);
  assign function_code_lines = state.fc;
  assign ack_addr_level = state.ack_level;
  assign autovector = state.vec;
  assign from_system_integration_block = state.ext_src;
endmodule // irr_recognizer
`default_nettype wire

/* File: shared/irr_pkg.sv */
// Package of constants and types for the interrupt request recognition block
`default_nettype none
package irr_pkg;
  // Number of request levels carried by lines (levels one to seven)
  localparam int unsigned NUM_LEVELS = 7;
  // Width of an encoded level and of the mask field
  localparam int unsigned LEVEL_W = 3;
  // Level carried by the non-maskable line
  localparam logic [2:0] NMI_LEVEL = 3'h7;
  // Mask value that lets every level through
  localparam logic [2:0] MASK_OPEN = 3'h0;
  // Mask field value after reset (all maskable levels blocked)
  localparam logic [2:0] MASK_RESET = 3'h7;
  // Function code driven during interrupt acknowledge (processor space)
  localparam logic [2:0] FC_CPU_SPACE = 3'h7;
  // Function code driven while idle
  localparam logic [2:0] FC_IDLE = 3'h0;
  // Number of automatic vectors, one per level
  localparam int unsigned AUTO_VECTORS = 7;
  // Number of vectors that requesting sources may assign
  localparam int unsigned ASSIGNABLE_VECTORS = 200;
  // Falling-edge samples a request must stay asserted to be valid
  localparam int unsigned MIN_ASSERT_SAMPLES = 2;
  // Request line value after reset (active low, so negated is ones)
  localparam logic [6:0] LINES_RESET = 7'h7F;
  // Autovector base number; level n takes base plus n
  localparam logic [7:0] AUTOVEC_BASE = 8'h18;

  // Acknowledge sequencer states, one-hot
  typedef enum logic [2:0] {
    IRR_IDLE = 3'b001,
    IRR_ACK = 3'b010,
    IRR_DONE = 3'b100
  } irr_state_t;
endpackage : irr_pkg
`default_nettype wire

/* File: rtl/irr_line_filter.sv */
// Per-line sampler and validity filter for one active-low request line
`default_nettype none
module irr_line_filter #(
  parameter int unsigned SAMPLES = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Falling-edge sample enable
  input wire logic sample_en,
  // Active-low request level, combined or external-only
  input wire logic request_n,
  // Filtered request valid, active high
  output logic valid
);
  // Filter state
  typedef struct packed {
    logic [SAMPLES-1:0] hist;
    logic valid;
  } irr_filt_t;

  irr_filt_t state;
  irr_filt_t next_state;

  // Shift in asserted samples; valid when all recent samples asserted
  always_comb
  begin
    next_state = state;
    if (sample_en)
    begin
      next_state.hist = {state.hist[SAMPLES-2:0], ~request_n};
      next_state.valid = &next_state.hist;
    end
  end

  // State register
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign valid = state.valid;
endmodule // irr_line_filter
`default_nettype wire

/* File: test/irr_requester.sv */
// Model of the outside devices that drive the request pins
`default_nettype none
module irr_requester (
  // Clock
  input wire logic clk_sys,
  // Commanded level, zero for none
  input wire logic [2:0] req_level,
  // Active-low request pins, negated pins rest high
  output logic [6:0] ext_request_n = 7'h7F
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk_sys)
  begin
    ext_request_n <= (req_level == 3'h0) ? 7'h7F : ~(7'h01 << (req_level - 3'h1));
  end
endmodule // irr_requester
`default_nettype wire

/* File: test/irr_recognizer_chk.sv */
// Port checks for the interrupt request recognition block
`default_nettype none
module irr_chk #(
  parameter int unsigned NUM_LEVELS = 7
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Request and core inputs
  input wire logic sample_en,
  input wire logic [NUM_LEVELS-1:0] ext_request_n,
  input wire logic [NUM_LEVELS-1:0] int_request_n,
  input wire logic take_boundary,
  input wire logic ack_done,
  input wire logic mask_write,
  input wire logic [2:0] mask_wdata,
  // Outputs under watch
  input wire logic [2:0] priority_mask_field,
  input wire logic [2:0] pending_level,
  input wire logic nmi_pending,
  input wire logic ack_active,
  input wire logic [2:0] function_code_lines,
  input wire logic [2:0] ack_addr_level,
  input wire logic [7:0] autovector,
  input wire logic from_system_integration_block
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // Take seen while the sequencer is idle
  sequence s_take;
    take_boundary && pending_level != 3'h0 && !ack_active && !$past(ack_active);
  endsequence
  // Done cycle then idle cycle
  sequence s_release;
    !ack_active ##1 !ack_active;
  endsequence
  fc_code_a: assert property (function_code_lines == (ack_active ? 3'h7 : 3'h0))
    else $error("function code wrong");
  take_load_a: assert property (s_take |=> ack_active && ack_addr_level == $past(pending_level)
    && priority_mask_field == $past(pending_level)) else $error("take not loaded");
  auto_vec_a: assert property ($rose(ack_active)
    |-> autovector == irr_pkg::AUTOVEC_BASE + 8'(ack_addr_level)) else $error("bad vector");
  ack_hold_a: assert property (ack_active && !ack_done |=> ack_active)
    else $error("acknowledge dropped");
  ack_end_a: assert property (ack_active && ack_done |=> s_release)
    else $error("acknowledge not ended");
  mask_gate_a: assert property (pending_level inside {[3'h1:3'h6]} |->
    pending_level > priority_mask_field || pending_level > $past(priority_mask_field))
    else $error("masked level pending");
  mask_keep_a: assert property (!mask_write && !take_boundary |=> $stable(priority_mask_field))
    else $error("mask changed");
  nmi_level_a: assert property ($rose(nmi_pending) |-> ##[0:1] pending_level == 3'h7)
    else $error("nmi not shown");
endmodule // irr_chk
bind irr_recognizer irr_chk #(.NUM_LEVELS(NUM_LEVELS)) i_irr_chk (.*);
`default_nettype wire

/* File: test/irr_bench.sv */
// Self-checking bench for the interrupt request recognition block
`default_nettype none
module irr_recognizer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Driven inputs
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic sample_en = 1'b0;
  logic take_boundary = 1'b0;
  logic ack_done = 1'b0;
  logic mask_write = 1'b0;
  logic [2:0] mask_wdata = 3'h0;
  logic [2:0] req_level = 3'h0;
  logic [6:0] int_request_n = 7'h7F;
  // Observed outputs
  logic [6:0] ext_request_n;
  logic [2:0] priority_mask_field, pending_level, function_code_lines, ack_addr_level;
  logic nmi_pending, ack_active, from_system_integration_block;
  logic [7:0] autovector;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  irr_recognizer i_irr_recognizer (
    .clk_sys(clk_sys),
    .reset(reset),
    .sample_en(sample_en),
    .ext_request_n(ext_request_n),
    .int_request_n(int_request_n),
    .take_boundary(take_boundary),
    .ack_done(ack_done),
    .mask_write(mask_write),
    .mask_wdata(mask_wdata),
    .priority_mask_field(priority_mask_field),
    .pending_level(pending_level),
    .nmi_pending(nmi_pending),
    .ack_active(ack_active),
    .function_code_lines(function_code_lines),
    .ack_addr_level(ack_addr_level),
    .autovector(autovector),
    .from_system_integration_block(from_system_integration_block)
  );
  irr_requester i_irr_requester (
    .clk_sys(clk_sys),
    .req_level(req_level),
    .ext_request_n(ext_request_n)
  );
  always #2 clk_sys = ~clk_sys;
  // Falling-edge sample pulse every other cycle, plus hang limit
  always @(posedge clk_sys)
  begin
    sample_en <= ~sample_en;
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fails++;
      end_of_test();
    end
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    if (seen !== exp)
      fails++;
  endtask
  task req(input logic [2:0] l);
    @(posedge clk_sys);
    req_level <= l;
  endtask
  task mask_set(input logic [2:0] m);
    @(posedge clk_sys);
    mask_wdata <= m;
    mask_write <= 1'b1;
    @(posedge clk_sys);
    mask_write <= 1'b0;
  endtask
  task wait_pend(input logic [2:0] l);
    repeat (20)
    begin
      @(negedge clk_sys);
      if (pending_level === l)
        break;
    end
    chk(8'(pending_level), 8'(l));
  endtask
  // Take at a boundary, check the acknowledge, then end it
  task serve(input logic [2:0] l);
    @(posedge clk_sys);
    take_boundary <= 1'b1;
    @(posedge clk_sys);
    take_boundary <= 1'b0;
    @(negedge clk_sys);
    chk(8'(function_code_lines), 8'h07);
    chk(8'(ack_addr_level), 8'(l));
    chk(8'(priority_mask_field), 8'(l));
    chk(autovector, irr_pkg::AUTOVEC_BASE + 8'(l));
    chk(8'(ack_active), 8'h01);
    @(posedge clk_sys);
    ack_done <= 1'b1;
    @(posedge clk_sys);
    ack_done <= 1'b0;
    @(negedge clk_sys);
    chk(8'(ack_active), 8'h00);
    chk(8'(function_code_lines), 8'h00);
    repeat (3) @(posedge clk_sys);
  endtask
  task t_levels;
    for (int l = 1; l < 8; l++)
    begin
      mask_set(3'h0);
      req(3'(l));
      wait_pend(3'(l));
      serve(3'(l));
      chk(8'(from_system_integration_block), 8'h01);
      req(3'h0);
      repeat (8) @(posedge clk_sys);
    end
    $display("levels test done");
  endtask
  task t_mask;
    mask_set(3'h3);
    req(3'h3);
    repeat (12) @(negedge clk_sys);
    chk(8'(pending_level), 8'h00);
    // A boundary with nothing pending starts no acknowledge
    @(posedge clk_sys);
    take_boundary <= 1'b1;
    @(posedge clk_sys);
    take_boundary <= 1'b0;
    @(negedge clk_sys);
    chk(8'(ack_active), 8'h00);
    @(posedge clk_sys);
    int_request_n <= 7'h6F;
    wait_pend(3'h5);
    serve(3'h5);
    chk(8'(from_system_integration_block), 8'h00);
    int_request_n <= 7'h7F;
    req(3'h0);
    mask_set(3'h0);
    req(3'h2);
    req(3'h0);
    repeat (12) @(negedge clk_sys);
    chk(8'(pending_level), 8'h00);
    // Higher level overtakes a pending lower one, which is not latched
    req(3'h2);
    wait_pend(3'h2);
    @(posedge clk_sys);
    int_request_n <= 7'h77;
    wait_pend(3'h4);
    serve(3'h4);
    int_request_n <= 7'h7F;
    mask_set(3'h0);
    wait_pend(3'h2);
    req(3'h0);
    wait_pend(3'h0);
    $display("mask test done");
  endtask
  task t_nmi;
    mask_set(3'h7);
    req(3'h7);
    wait_pend(3'h7);
    chk(8'(nmi_pending), 8'h01);
    serve(3'h7);
    repeat (12) @(negedge clk_sys);
    chk(8'(nmi_pending), 8'h00);
    mask_set(3'h3);
    wait_pend(3'h7);
    serve(3'h7);
    req(3'h0);
    $display("nmi test done");
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk(8'(priority_mask_field), 8'h07);
    t_levels();
    t_mask();
    t_nmi();
    end_of_test();
  end
endmodule // irr_recognizer_bench
`default_nettype wire
